// File: shared/bank_if.sv
// Interface between the statistics controller and its counter bank.
`timescale 1ns/1ps
interface bank_if;
   logic [stat_pkg::NCNT-1:0] inc;
   logic clr;
   logic [stat_pkg::BIDXW-1:0] rd_idx;
   logic [stat_pkg::CW-1:0] rd_data;

   modport ctrl (output inc, output clr, output rd_idx, input rd_data);
   modport bank (input inc, input clr, input rd_idx, output rd_data);
endinterface

// File: shared/stat_pkg.sv
// Shared constants for the per-port frame statistics counter block.
package stat_pkg;

   // Counter geometry.
   localparam int NCNT = 32;
   localparam int CW = 32;
   localparam int OW = 64;
   localparam int BIDXW = 5;
   localparam int SELW = 6;

   // Frame length thresholds in octets, FCS included.
   localparam logic [15:0] LEN_64 = 16'h0040;
   localparam logic [15:0] LEN_127 = 16'h007f;
   localparam logic [15:0] LEN_255 = 16'h00ff;
   localparam logic [15:0] LEN_511 = 16'h01ff;
   localparam logic [15:0] LEN_1023 = 16'h03ff;
   localparam logic [15:0] LEN_1518 = 16'h05ee;
   localparam logic [15:0] LEN_1522 = 16'h05f2;
   localparam logic [15:0] LEN_1530 = 16'h05fa;
   localparam logic [15:0] TX_MAX_LEN = 16'h05ee;

   // Length bin codes returned by the bin decoder.
   localparam logic [3:0] BIN_UNDER = 4'h0;
   localparam logic [3:0] BIN_64 = 4'h1;
   localparam logic [3:0] BIN_ABOVE = 4'h8;
   localparam int RX_NBIN = 8;
   localparam int TX_NBIN = 7;

   // Counter bank indices.
   localparam int C_RX_BIN0 = 0;
   localparam int C_RX_UCAST = 8;
   localparam int C_RX_MCAST = 9;
   localparam int C_RX_BCAST = 10;
   localparam int C_JABBER = 11;
   localparam int C_UNDERSIZE = 12;
   localparam int C_ALIGN = 13;
   localparam int C_RX_FCS = 14;
   localparam int C_RX_PAUSE = 15;
   localparam int C_RX_GOOD = 16;
   localparam int C_RX_DISCARD = 17;
   localparam int C_TX_BIN0 = 18;
   localparam int C_TX_UCAST = 25;
   localparam int C_TX_MCAST = 26;
   localparam int C_TX_BCAST = 27;
   localparam int C_TX_FCS = 28;
   localparam int C_TX_OVERSIZE = 29;
   localparam int C_TX_OK = 30;
   localparam int C_TX_DISCARD = 31;

   // Counters that survive a clear command.
   localparam logic [NCNT-1:0] KEEP_MASK = 32'h8002_0000;

   // Read selects above the bank.
   localparam logic [SELW-1:0] SEL_RX_OCTETS = 6'h20;
   localparam logic [SELW-1:0] SEL_TX_OCTETS = 6'h21;
   localparam logic [SELW-1:0] SEL_TX_ERRORS = 6'h22;
   localparam logic [SELW-1:0] SEL_ELAPSED = 6'h23;

   // Elapsed time base.
   localparam longint SEC_TIME_NS = 1000000000;
   localparam longint CLK_PERIOD_NS = 10;
   localparam int unsigned CYC_PER_SEC = int'(SEC_TIME_NS / CLK_PERIOD_NS);
   localparam logic [5:0] LAST_SEC = 6'h3b;
   localparam logic [5:0] LAST_MIN = 6'h3b;
   localparam logic [4:0] LAST_HOUR = 5'h17;

endpackage

// File: sim/mac_path_model.sv
// Behavioural receive and transmit datapaths that report frame events.
`timescale 1ns/1ps
module mac_path_model (
   input wire logic clk,
   output logic [15:0] rl,
   output logic [8:0] rf,
   output logic [15:0] tl,
   output logic [10:0] tf
);
   initial begin
      rl = 16'h0;
      rf = 9'h0;
      tl = 16'h0;
      tf = 11'h0;
   end
   // One cycle of activity. A length not qualified by its end strobe is scrambled, so that
   // the block cannot lean on a stale value; broadcast always carries the group bit.
   task automatic cyc(input logic [15:0] l, input logic [8:0] f, input logic [15:0] m,
      input logic [10:0] g);
      @(posedge clk);
      #1;
      rl = f[0] ? l : ~rl;
      rf = {f[8:5], f[4], f[3] | f[4], f[2:0]};
      tl = g[3] ? m : ~tl;
      tf = {g[10:3], g[2], g[1] | g[2], g[0]};
   endtask
endmodule

// File: sim/port_frame_statistics_counters_tb_top.sv
// Self-checking bench for the per-port frame statistics counters.
`timescale 1ns/1ps
module port_frame_statistics_counters_tb_top;
   localparam int unsigned CPS = 10;
   logic REF_CLK = 1'b0, RST = 1'b1, CLEAR = 1'b0, RD_REQ = 1'b0, RD_VALID;
   logic [5:0] RD_SEL = 6'h0, MINS, SECS;
   logic [63:0] RD_DATA;
   logic [15:0] DAYS, rl, tl;
   logic [4:0] HOURS;
   logic [8:0] rf;
   logic [10:0] tf;
   logic [63:0] ex [0:35];
   logic [63:0] expq [$];
   int mismatches = 0, compares = 0;
   logic [31:0] seed = 32'h79dc3eba;
   int bl [15] = '{63, 64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 1518, 1519, 1522, 1523};
   int bt [15] = '{64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 1518, 1519, 1522, 1530, 1531};

   initial forever #5 REF_CLK = ~REF_CLK;

   mac_path_model pm (.clk(REF_CLK), .rl(rl), .rf(rf), .tl(tl), .tf(tf));
   port_frame_statistics_counters #(.CYC_PER_SEC(CPS)) dut_u (
      .REF_CLK(REF_CLK), .RST(RST), .CLEAR(CLEAR),
      .RX_END(rf[0]), .RX_LEN(rl), .RX_FCS_BAD(rf[1]), .RX_PARTIAL(rf[2]),
      .RX_MCAST(rf[3]), .RX_BCAST(rf[4]), .RX_DELIVER(rf[5]), .RX_PAUSE(rf[6]),
      .RX_DISCARD(rf[7]), .HALF_DUPLEX(rf[8]), .TX_REQ(tf[0]), .TX_REQ_MCAST(tf[1]),
      .TX_REQ_BCAST(tf[2]), .TX_END(tf[3]), .TX_FCS_BAD(tf[4]), .TX_PARTIAL(tf[5]),
      .TX_OK(tf[6]), .TX_COL_SINGLE(tf[7]), .TX_COL_MULTI(tf[8]), .TX_COL_EXCESS(tf[9]),
      .TX_DISCARD(tf[10]), .TX_LEN(tl), .RD_REQ(RD_REQ), .RD_SEL(RD_SEL),
      .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .DAYS(DAYS), .HOURS(HOURS), .MINS(MINS),
      .SECS(SECS));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic int rbin(input int n);
      return n == 64 ? 0 : n <= 127 ? 1 : n <= 255 ? 2 : n <= 511 ? 3 : n <= 1023 ? 4 :
         n <= 1518 ? 5 : n <= 1522 ? 6 : 7;
   endfunction

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("Compares %0d, mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Present one cycle of events and add their effect to the expected counters.
   task automatic ev(input int l, input logic [8:0] f, input int m, input logic [10:0] g);
      logic mc, in_r, in_t;
      mc = f[3] | f[4];
      in_r = l >= 64 && l <= 1518;
      in_t = m >= 64 && m <= 1518;
      pm.cyc(16'(l), f, 16'(m), g);
      if (f[0]) begin
         ex[32] += 64'(l);
         if (l < 64) ex[12]++;
         else ex[rbin(l)]++;
         if (f[5] && !mc) ex[8]++;
         if (mc && !f[4]) ex[9]++;
         if (f[4]) ex[10]++;
         if (f[1] && l > 1518) ex[11]++;
         if (in_r && f[1] && f[2]) ex[13]++;
         if (in_r && f[1] && !f[2]) ex[14]++;
         if (f[6] && !f[8]) ex[15]++;
         if (!f[1] && l >= 64) ex[16]++;
      end
      if (f[7]) ex[17]++;
      if (g[0]) ex[g[2] ? 27 : (g[1] ? 26 : 25)]++;
      if (g[3]) begin
         ex[33] += 64'(m);
         if (m <= 1530) ex[18 + (m > 1518 ? 6 : rbin(m))]++;
         if (in_t && g[4] && !g[5]) ex[28]++;
         if (m > 1518) ex[29]++;
         if (g[6]) ex[30]++;
      end
      if (g[10]) ex[31]++;
      ex[34] += 64'(g[7]) + 64'(g[8]) + 64'(g[9]);
   endtask

   // Pipelined reads of every select; the elapsed time is skipped as it moves during the sweep.
   task automatic rd_all();
      ev(0, 9'h0, 0, 11'h0);
      for (int s = 0; s < 64; s++) begin
         if (s == 35) continue;
         @(posedge REF_CLK);
         #1;
         RD_REQ = 1'b1;
         RD_SEL = 6'(s);
         expq.push_back(s < 35 ? ex[s] : 64'h0);
      end
      @(posedge REF_CLK);
      #1;
      RD_REQ = 1'b0;
      RD_SEL = 6'(rnd());
   endtask

   task automatic clear_pulse();
      @(posedge REF_CLK);
      #1;
      CLEAR = 1'b1;
      @(posedge REF_CLK);
      #1;
      CLEAR = 1'b0;
   endtask

   // Each read answer is matched against the oldest expectation.
   always @(posedge REF_CLK) begin
      if (RD_VALID === 1'b1) begin
         if (expq.size() == 0) begin
            mismatches++;
            $display("MISMATCH at %0t: unexpected read answer", $time);
         end
         else chk(RD_DATA, expq.pop_front());
      end
   end

   initial begin
      repeat (20) @(posedge REF_CLK);
      #1;
      RST = 1'b0;
      foreach (ex[i]) ex[i] = 64'h0;
      rd_all();
      for (int k = 0; k < 4; k++) begin
         foreach (bl[i]) ev(bl[i], {6'(rnd()), 2'(k), 1'b1}, bt[i],
            {5'(rnd()), 2'(k), 1'b1, 3'(rnd())});
      end
      repeat (300) ev(int'(1 + rnd() % 1600), 9'(rnd()), int'(64 + rnd() % 1500), 11'(rnd()));
      rd_all();
      clear_pulse();
      foreach (ex[i]) if (i != 17 && i != 31) ex[i] = 64'h0;
      rd_all();
      clear_pulse();
      // Long enough to carry seconds into minutes and minutes into hours.
      repeat (3661 * CPS + 4) @(posedge REF_CLK);
      chk(64'({DAYS, HOURS, MINS, SECS}), 64'({16'h0, 5'h1, 6'h1, 6'h1}));
      clear_pulse();
      chk(64'({DAYS, HOURS, MINS, SECS}), 64'h0);
      repeat (4) @(posedge REF_CLK);
      chk(64'(expq.size()), 64'h0);
      give_verdict();
   end

   // Watchdog well beyond the longest expected run.
   initial begin
      repeat (60000) @(posedge REF_CLK);
      mismatches++;
      give_verdict();
   end
endmodule

// File: sim/stat_port_checker_asserts.sv
// Port-level timing checks for the frame statistics block.
`timescale 1ns/1ps
module stat_port_checker #(
   parameter int unsigned CYC_PER_SEC = 10
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic CLEAR,
   input wire logic RD_REQ,
   input wire logic [5:0] RD_SEL,
   input wire logic [63:0] RD_DATA,
   input wire logic RD_VALID,
   input wire logic [15:0] DAYS,
   input wire logic [4:0] HOURS,
   input wire logic [5:0] MINS,
   input wire logic [5:0] SECS
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   logic [5:0] secs_q;
   int unsigned gap_q;
   logic armed_q;
   wire tick = SECS != secs_q;
   // Spacing is judged only between two clean ticks, since clear and reset restart the divider.
   always_ff @(posedge REF_CLK) begin
      secs_q <= SECS;
      gap_q <= (RST | CLEAR | tick) ? 0 : gap_q + 1;
      armed_q <= (RST | CLEAR) ? 1'b0 : (tick | armed_q);
   end
   a_read_answer_lat: assert property (RD_REQ |-> ##2 RD_VALID)
      else $error("read answer missing two cycles after request");
   a_valid_has_req: assert property (RD_VALID |-> $past(RD_REQ, 2))
      else $error("read answer without a request");
   a_upper_bits_zero: assert property (RD_VALID && $past(RD_SEL, 2) < 6'h20 |->
      RD_DATA[63:32] == 32'h0) else $error("frame counter upper bits set");
   a_unmapped_reads_zero: assert property (RD_VALID && $past(RD_SEL, 2) > 6'h23 |->
      RD_DATA == 64'h0) else $error("unmapped select returned data");
   a_clear_time_zero: assert property (CLEAR |=> {DAYS, HOURS, MINS, SECS} == 33'h0)
      else $error("elapsed time not restarted by clear");
   a_time_in_range: assert property (SECS <= stat_pkg::LAST_SEC && MINS <= stat_pkg::LAST_MIN
      && HOURS <= stat_pkg::LAST_HOUR) else $error("time field out of range");
   a_secs_step: assert property (tick && !$past(CLEAR) |-> SECS == secs_q + 6'h1 ||
      (secs_q == stat_pkg::LAST_SEC && SECS == 6'h0)) else $error("seconds skipped");
   a_mins_carry: assert property ($changed(MINS) && !$past(CLEAR) |->
      $past(SECS) == stat_pkg::LAST_SEC && SECS == 6'h0) else $error("bad minute carry");
   a_tick_spacing: assert property (tick && armed_q |-> gap_q == CYC_PER_SEC - 1)
      else $error("second length wrong");
   a_reset_zero: assert property (@(posedge REF_CLK) disable iff (1'b0) RST |=> !RD_VALID &&
      RD_DATA == 64'h0 && {DAYS, HOURS, MINS, SECS} == 33'h0) else $error("reset values");
   c_read_octets: cover property (RD_VALID && $past(RD_SEL, 2) == 6'h20);
   c_minute_carry: cover property ($changed(MINS));
   c_clear: cover property (CLEAR);
endmodule
bind port_frame_statistics_counters stat_port_checker #(.CYC_PER_SEC(CYC_PER_SEC)) chk_u (
   .REF_CLK(REF_CLK), .RST(RST), .CLEAR(CLEAR), .RD_REQ(RD_REQ), .RD_SEL(RD_SEL),
   .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .DAYS(DAYS), .HOURS(HOURS), .MINS(MINS),
   .SECS(SECS));

// File: verilog/port_frame_statistics_counters.sv
// Per-port receive and transmit frame statistics counters with elapsed time since clear.
`timescale 1ns/1ps

// Overview of operation
// - Add each received frame length, bad frames too, FCS included, to receive octets.
// - Count received frames of exactly 64 octets, good or bad.
// - Count received frames in 65-127, 128-255, 256-511, 512-1023 octet bins.
// - Count received frames in 1024-1518, 1519-1522 and above-1522 octet bins.
// - Count individually addressed received frames delivered upward.
// - Count received multicast frames, broadcast excluded.
// - Count received broadcast frames, other multicast excluded.
// - Count received frames over 1518 octets with bad FCS as jabbers.
// - Count received frames under 64 octets as fragments or undersize.
// - Count 64-1518 octet frames with bad FCS and odd bits as alignment errors.
// - Count 64-1518 octet frames with bad FCS on whole octets as FCS errors.
// - Count received PAUSE frames, never while in half duplex.
// - Add each transmitted frame length, bad frames too, to transmit octets.
// - Count transmitted frames in 64 up to 1024-1518 octet bins.
// - Count transmitted frames of 1519 to 1530 octets in one bin.
// - Count transmit requests by unicast, multicast, broadcast, discards included.
// - Total transmit errors sum single, multiple and excessive collision events.
// - Count transmitted 64-1518 octet frames with bad FCS on whole octets.
// - Count transmitted frames above the maximum permitted frame size.
// - Clear zeroes all statistics except the two discard counts.
// - Count frames sent onto the segment without error.
// - Keep days, hours, minutes, seconds since the last clear; restart on clear.
module port_frame_statistics_counters #(
   parameter int unsigned CYC_PER_SEC = stat_pkg::CYC_PER_SEC
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic CLEAR,
   input wire logic RX_END,
   input wire logic [15:0] RX_LEN,
   input wire logic RX_FCS_BAD,
   input wire logic RX_PARTIAL,
   input wire logic RX_MCAST,
   input wire logic RX_BCAST,
   input wire logic RX_DELIVER,
   input wire logic RX_PAUSE,
   input wire logic RX_DISCARD,
   input wire logic HALF_DUPLEX,
   input wire logic TX_REQ,
   input wire logic TX_REQ_MCAST,
   input wire logic TX_REQ_BCAST,
   input wire logic TX_DISCARD,
   input wire logic TX_END,
   input wire logic [15:0] TX_LEN,
   input wire logic TX_FCS_BAD,
   input wire logic TX_PARTIAL,
   input wire logic TX_OK,
   input wire logic TX_COL_SINGLE,
   input wire logic TX_COL_MULTI,
   input wire logic TX_COL_EXCESS,
   input wire logic RD_REQ,
   input wire logic [5:0] RD_SEL,
   output logic [63:0] RD_DATA,
   output logic RD_VALID,
   output logic [15:0] DAYS,
   output logic [4:0] HOURS,
   output logic [5:0] MINS,
   output logic [5:0] SECS
);

   // Bin decoder shared by both directions; top sets the upper edge of bin 7, the one above 1518.
   function automatic logic [3:0] len_bin(input logic [15:0] len, input logic [15:0] top);
      logic [3:0] b;
      b = stat_pkg::BIN_ABOVE;
      if (len < stat_pkg::LEN_64) begin
         b = stat_pkg::BIN_UNDER;
      end else if (len == stat_pkg::LEN_64) begin
         b = stat_pkg::BIN_64;
      end else if (len <= stat_pkg::LEN_127) begin
         b = 4'h2;
      end else if (len <= stat_pkg::LEN_255) begin
         b = 4'h3;
      end else if (len <= stat_pkg::LEN_511) begin
         b = 4'h4;
      end else if (len <= stat_pkg::LEN_1023) begin
         b = 4'h5;
      end else if (len <= stat_pkg::LEN_1518) begin
         b = 4'h6;
      end else if (len <= top) begin
         b = 4'h7;
      end
      return b;
   endfunction

   // Range test for the error classes that apply to normal-length frames.
   function automatic logic in_norm(input logic [15:0] len);
      return (len >= stat_pkg::LEN_64) && (len <= stat_pkg::LEN_1518);
   endfunction

   bank_if bus ();

   logic [3:0] rx_bin;
   logic [3:0] tx_bin;
   logic rx_norm;
   logic tx_norm;
   logic [stat_pkg::NCNT-1:0] inc;

   // Length classification happens on the end-of-frame strobe, once the length is final.
   assign rx_bin = len_bin(RX_LEN, stat_pkg::LEN_1522);
   assign tx_bin = len_bin(TX_LEN, stat_pkg::LEN_1530);
   assign rx_norm = in_norm(RX_LEN);
   assign tx_norm = in_norm(TX_LEN);

   // Receive bins: codes 1 to 8 map onto eight consecutive counters.
   genvar g;
   generate
      for (g = 0; g < stat_pkg::RX_NBIN; g++) begin : gen_rx_bin
         assign inc[stat_pkg::C_RX_BIN0 + g] = RX_END && (rx_bin == 4'(g + 1));
      end
      for (g = 0; g < stat_pkg::TX_NBIN; g++) begin : gen_tx_bin
         assign inc[stat_pkg::C_TX_BIN0 + g] = TX_END && (tx_bin == 4'(g + 1));
      end
   endgenerate

   // Receive address classes; broadcast is a multicast address but counted apart.
   assign inc[stat_pkg::C_RX_UCAST] = RX_END && RX_DELIVER && !RX_MCAST;
   assign inc[stat_pkg::C_RX_MCAST] = RX_END && RX_MCAST && !RX_BCAST;
   assign inc[stat_pkg::C_RX_BCAST] = RX_END && RX_BCAST;

   // Receive error classes.
   assign inc[stat_pkg::C_JABBER] = RX_END && RX_FCS_BAD && (RX_LEN > stat_pkg::LEN_1518);
   assign inc[stat_pkg::C_UNDERSIZE] = RX_END && (rx_bin == stat_pkg::BIN_UNDER);
   assign inc[stat_pkg::C_ALIGN] = RX_END && rx_norm && RX_FCS_BAD && RX_PARTIAL;
   assign inc[stat_pkg::C_RX_FCS] = RX_END && rx_norm && RX_FCS_BAD && !RX_PARTIAL;

   // Flow control frames only count in full duplex.
   assign inc[stat_pkg::C_RX_PAUSE] = RX_END && RX_PAUSE && !HALF_DUPLEX;

   // Good receive frames and discards; the discard count survives a clear command.
   assign inc[stat_pkg::C_RX_GOOD] = RX_END && !RX_FCS_BAD && (rx_bin != stat_pkg::BIN_UNDER);
   assign inc[stat_pkg::C_RX_DISCARD] = RX_DISCARD;

   // Transmit requests are counted when asked for, before the frame is sent or dropped.
   assign inc[stat_pkg::C_TX_UCAST] = TX_REQ && !TX_REQ_MCAST;
   assign inc[stat_pkg::C_TX_MCAST] = TX_REQ && TX_REQ_MCAST && !TX_REQ_BCAST;
   assign inc[stat_pkg::C_TX_BCAST] = TX_REQ && TX_REQ_BCAST;

   // Transmit error and success classes.
   assign inc[stat_pkg::C_TX_FCS] = TX_END && tx_norm && TX_FCS_BAD && !TX_PARTIAL;
   assign inc[stat_pkg::C_TX_OVERSIZE] = TX_END && (TX_LEN > stat_pkg::TX_MAX_LEN);
   assign inc[stat_pkg::C_TX_OK] = TX_END && TX_OK;
   assign inc[stat_pkg::C_TX_DISCARD] = TX_DISCARD;

   // Hand the increment vector, clear and read index to the bank.
   assign bus.inc = inc;
   assign bus.clr = CLEAR;
   assign bus.rd_idx = RD_SEL[stat_pkg::BIDXW-1:0];

   stat_bank u_bank (
      .clk(REF_CLK),
      .rst(RST),
      .bus(bus)
   );

   logic [stat_pkg::OW-1:0] rx_oct_q;
   logic [stat_pkg::OW-1:0] rx_oct_d;
   logic [stat_pkg::OW-1:0] tx_oct_q;
   logic [stat_pkg::OW-1:0] tx_oct_d;
   logic [stat_pkg::OW-1:0] rx_add;
   logic [stat_pkg::OW-1:0] tx_add;

   // Octet totals are 64 bits so they do not wrap in any practical sampling interval.
   assign rx_add = RX_END ? {48'h0, RX_LEN} : '0;
   assign tx_add = TX_END ? {48'h0, TX_LEN} : '0;
   assign rx_oct_d = (CLEAR ? '0 : rx_oct_q) + rx_add;
   assign tx_oct_d = (CLEAR ? '0 : tx_oct_q) + tx_add;

   // Octet accumulators; an addition in the clear cycle is kept.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rx_oct_q <= '0;
         tx_oct_q <= '0;
      end else begin
         rx_oct_q <= rx_oct_d;
         tx_oct_q <= tx_oct_d;
      end
   end

   logic [stat_pkg::CW-1:0] tx_err_q;
   logic [stat_pkg::CW-1:0] tx_err_d;
   logic [1:0] col_sum;

   // Collision events may coincide, so the total adds their count, not just one.
   assign col_sum = 2'({1'b0, TX_COL_SINGLE} + {1'b0, TX_COL_MULTI} + {1'b0, TX_COL_EXCESS});
   assign tx_err_d = (CLEAR ? '0 : tx_err_q) + {30'h0, col_sum};

   // Total transmit error register.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         tx_err_q <= '0;
      end else begin
         tx_err_q <= tx_err_d;
      end
   end

   logic [31:0] div_q;
   logic sec_tick;
   logic sec_wrap;
   logic min_wrap;
   logic hour_wrap;

   // One-second enable from the reference clock.
   assign sec_tick = (div_q == 32'(CYC_PER_SEC - 1));
   assign sec_wrap = sec_tick && (SECS == stat_pkg::LAST_SEC);
   assign min_wrap = sec_wrap && (MINS == stat_pkg::LAST_MIN);
   assign hour_wrap = min_wrap && (HOURS == stat_pkg::LAST_HOUR);

   // Second divider restarts with the clear so the first second is a full one.
   always_ff @(posedge REF_CLK) begin
      if (RST || CLEAR) begin
         div_q <= '0;
      end else if (sec_tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 32'h1;
      end
   end

   // Elapsed time fields; days saturate rather than wrap to zero.
   always_ff @(posedge REF_CLK) begin
      if (RST || CLEAR) begin
         SECS <= '0;
         MINS <= '0;
         HOURS <= '0;
         DAYS <= '0;
      end else if (sec_tick) begin
         SECS <= sec_wrap ? 6'h00 : SECS + 6'h01;
         if (sec_wrap) begin
            MINS <= min_wrap ? 6'h00 : MINS + 6'h01;
         end
         if (min_wrap) begin
            HOURS <= hour_wrap ? 5'h00 : HOURS + 5'h01;
         end
         if (hour_wrap && (DAYS != 16'hffff)) begin
            DAYS <= DAYS + 16'h0001;
         end
      end
   end

   logic rd_pend_q;
   logic [stat_pkg::SELW-1:0] sel_q;
   logic [stat_pkg::OW-1:0] rd_mux;
   logic [stat_pkg::OW-1:0] elapsed;

   // Packed elapsed time: days, hours, minutes, seconds from the top down.
   assign elapsed = {31'h0, DAYS, HOURS, MINS, SECS};

   // Read selection; unmapped selects read as zero.
   assign rd_mux = (sel_q < stat_pkg::SELW'(stat_pkg::NCNT)) ? {32'h0, bus.rd_data} :
                   (sel_q == stat_pkg::SEL_RX_OCTETS) ? rx_oct_q :
                   (sel_q == stat_pkg::SEL_TX_OCTETS) ? tx_oct_q :
                   (sel_q == stat_pkg::SEL_TX_ERRORS) ? {32'h0, tx_err_q} :
                   (sel_q == stat_pkg::SEL_ELAPSED) ? elapsed : '0;

   // Read request stage: the bank samples its index on the same edge.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rd_pend_q <= 1'b0;
         sel_q <= '0;
      end else begin
         rd_pend_q <= RD_REQ;
         sel_q <= RD_SEL;
      end
   end

   // Read answer stage; data hold until the next answer.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         RD_DATA <= '0;
         RD_VALID <= 1'b0;
      end else begin
         RD_VALID <= rd_pend_q;
         if (rd_pend_q) begin
            RD_DATA <= rd_mux;
         end
      end
   end

endmodule

// File: verilog/stat_bank.sv
// Bank of 32-bit event counters with a registered read port.
`timescale 1ns/1ps
module stat_bank (
   input wire logic clk,
   input wire logic rst,
   bank_if.bank bus
);

   logic [stat_pkg::CW-1:0] cnt_q [stat_pkg::NCNT];
   logic [stat_pkg::CW-1:0] rd_q;

   // One counter per entry; an increment in the clear cycle survives as one.
   genvar g;
   generate
      for (g = 0; g < stat_pkg::NCNT; g++) begin : gen_cnt
         logic [stat_pkg::CW-1:0] base_d;
         logic [stat_pkg::CW-1:0] cnt_d;
         assign base_d = (bus.clr && !stat_pkg::KEEP_MASK[g]) ? '0 : cnt_q[g];
         assign cnt_d = base_d + {{(stat_pkg::CW-1){1'b0}}, bus.inc[g]};
         always_ff @(posedge clk) begin
            if (rst) begin
               cnt_q[g] <= '0;
            end else begin
               cnt_q[g] <= cnt_d;
            end
         end
      end
   endgenerate

   // Read data are registered so the bank maps onto a register file.
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_q <= '0;
      end else begin
         rd_q <= cnt_q[bus.rd_idx];
      end
   end

   assign bus.rd_data = rd_q;

endmodule
